// ==== design/field_locked_audio_clock_gen.sv ====
// Operation
// - master clock out runs at 256 times sample rate, 11.2896 MHz example
// - bit clock is 32x sample rate, word clock equals sample rate
// - 18-bit cycles per field at 30..32, low byte first
// - 22-bit nominal increment at 34..36, low byte first, top six bits
// - 6-bit ratio at 38 divides master clock in to bit clock
// - 6-bit ratio at 39 divides bit clock to word clock
// - setup byte at 3A: loop, voltage range, word phase, bit phase
`timescale 1ns/1ps
`default_nettype none

module field_locked_audio_clock_gen
   import audio_clock_pkg::*;
(
   // clock and reset (clk_sys is the crystal reference)
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   // video timing
   input  wire logic       field_start,
   // audio clocks
   output logic            audio_master_clock_out,
   input  wire logic       audio_master_clock_in,
   output logic            audio_bit_clock,
   output logic            audio_word_clock,
   output logic            master_clock_voltage_range,
   // loop status
   output logic [CPF_W-1:0] field_count_last
);

   // field lock loop sequencing
   typedef enum logic [1:0] {
      LOOP_OFF,
      LOOP_ALIGN,
      LOOP_TRACK
   } loop_state_t;

   typedef struct packed {
      logic [CPF_W-1:0]   cpf;
      logic [NI_W-1:0]    ni;
      logic [RATIO_W-1:0] bit_ratio;
      logic [RATIO_W-1:0] word_ratio;
      logic [3:0]         setup;
      logic [ACC_W-1:0]   acc;
      logic signed [NI_W:0] trim;
      logic [CPF_W-1:0]   cnt;
      logic [CPF_W-1:0]   last;
      logic               mclk_in_d1;
      logic               mclk_in_d2;
      logic               mclk_in_d3;
      logic [7:0]         rdata;
      loop_state_t        loop;
   } gen_state_t;

   gen_state_t st_r;
   gen_state_t st_nxt;

   logic              in_rise;
   logic              bit_tick;
   logic              bit_clk_raw;
   logic              word_clk_raw;
   logic [NI_W-1:0]   eff_inc;
   logic [RATIO_W-1:0] word_ratio_eff;

   // saturating add of signed trim onto increment
   function automatic logic [NI_W-1:0] apply_trim(input logic [NI_W-1:0] base,
                                                  input logic signed [NI_W:0] t);
      logic signed [NI_W+1:0] s;
      s = $signed({2'b00, base}) + {t[NI_W], t};
      if (s < 0)
         apply_trim = '0;
      else if (s[NI_W])
         apply_trim = '1;
      else
         apply_trim = s[NI_W-1:0];
   endfunction

   // read mux; reserved and unmapped addresses read zero
   function automatic logic [7:0] read_reg(input gen_state_t s, input logic [7:0] a);
      case (a)
         ADDR_CPF_LOW:     read_reg = s.cpf[7:0];
         ADDR_CPF_MID:     read_reg = s.cpf[15:8];
         ADDR_CPF_HIGH:    read_reg = {6'h00, s.cpf[17:16]};
         ADDR_NI_LOW:      read_reg = s.ni[7:0];
         ADDR_NI_MID:      read_reg = s.ni[15:8];
         ADDR_NI_HIGH:     read_reg = {2'h0, s.ni[21:16]};
         ADDR_BIT_DIV:     read_reg = {2'h0, s.bit_ratio};
         ADDR_WORD_DIV:    read_reg = {2'h0, s.word_ratio};
         ADDR_BASIC_SETUP: read_reg = {4'h0, s.setup};
         default:          read_reg = 8'h00;
      endcase
   endfunction

   // register write; reserved places and undocumented bits are dropped
   function automatic gen_state_t write_reg(input gen_state_t s,
                                            input logic [7:0] a,
                                            input logic [7:0] d);
      write_reg = s;
      case (a)
         ADDR_CPF_LOW:
         begin
            write_reg.cpf[7:0] = d;
         end
         ADDR_CPF_MID:
         begin
            write_reg.cpf[15:8] = d;
         end
         ADDR_CPF_HIGH:
         begin
            write_reg.cpf[17:16] = d[1:0];
         end
         ADDR_NI_LOW:
         begin
            write_reg.ni[7:0] = d;
         end
         ADDR_NI_MID:
         begin
            write_reg.ni[15:8] = d;
         end
         ADDR_NI_HIGH:
         begin
            write_reg.ni[21:16] = d[5:0];
         end
         ADDR_BIT_DIV:
         begin
            write_reg.bit_ratio = d[5:0];
         end
         ADDR_WORD_DIV:
         begin
            write_reg.word_ratio = d[5:0];
         end
         ADDR_BASIC_SETUP:
         begin
            write_reg.setup = d[3:0];
         end
         default:
         begin
            write_reg = s;
         end
      endcase
   endfunction

   // one trim step per field; small steps keep the master clock free of jumps
   function automatic logic signed [NI_W:0] next_trim(input logic [CPF_W-1:0]    cnt,
                                                      input logic [CPF_W-1:0]    target,
                                                      input logic signed [NI_W:0] t);
      logic signed [NI_W:0] step;
      logic signed [NI_W:0] limit;
      step      = $signed((NI_W+1)'(1 << TRIM_SHIFT));
      limit     = $signed((NI_W+1)'(TRIM_LIMIT));
      next_trim = t;
      if (cnt < target)
      begin
         if (t < limit)
         begin
            next_trim = t + step;
         end
      end
      else if (cnt > target)
      begin
         if (t > -limit)
         begin
            next_trim = t - step;
         end
      end
   endfunction

   // the word divider counts whole bit periods and wraps after ratio of them,
   // so 0x10 gives 32 bit clocks per word; ratio 0 behaves like 1
   function automatic logic [RATIO_W-1:0] word_div_ratio(input logic [RATIO_W-1:0] r);
      if (r == '0)
         word_div_ratio = '0;
      else
         word_div_ratio = r - 6'h01;
   endfunction

   assign eff_inc = st_r.setup[SETUP_LOOP_BIT] ? apply_trim(st_r.ni, st_r.trim) : st_r.ni;
   assign in_rise = st_r.mclk_in_d2 & ~st_r.mclk_in_d3;

   always_comb
   begin
      st_nxt = st_r;
      // register writes take effect at once, there is no shadow copy
      if (reg_wr)
      begin
         st_nxt = write_reg(st_r, reg_addr, reg_wdata);
      end
      if (reg_rd)
      begin
         st_nxt.rdata = read_reg(st_r, reg_addr);
      end

      // phase accumulator, msb is the master clock
      st_nxt.acc = st_r.acc + {1'b0, eff_inc};

      // returned master clock, synchroniser then edge detect on later stages
      st_nxt.mclk_in_d1 = audio_master_clock_in;
      st_nxt.mclk_in_d2 = st_r.mclk_in_d1;
      st_nxt.mclk_in_d3 = st_r.mclk_in_d2;

      // a rise in the field_start cycle already belongs to the new field
      if (field_start)
      begin
         st_nxt.cnt  = in_rise ? 18'h0_0001 : 18'h0_0000;
         st_nxt.last = st_r.cnt;
      end
      else if (in_rise && st_r.cnt != '1)
      begin
         st_nxt.cnt = st_r.cnt + 18'h0_0001;
      end

      // the first field after the loop is switched on holds a partial count,
      // so it only restarts the counter and never steers the trim
      case (st_r.loop)
         LOOP_OFF:
         begin
            st_nxt.trim = '0;
            if (st_r.setup[SETUP_LOOP_BIT])
               st_nxt.loop = LOOP_ALIGN;
         end
         LOOP_ALIGN:
         begin
            if (!st_r.setup[SETUP_LOOP_BIT])
               st_nxt.loop = LOOP_OFF;
            else if (field_start)
               st_nxt.loop = LOOP_TRACK;
         end
         LOOP_TRACK:
         begin
            if (!st_r.setup[SETUP_LOOP_BIT])
            begin
               st_nxt.loop = LOOP_OFF;
            end
            else if (field_start)
            begin
               st_nxt.trim = next_trim(st_r.cnt, st_r.cpf, st_r.trim);
            end
         end
         default:
         begin
            st_nxt.loop = LOOP_OFF;
         end
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         st_r            <= '0;
         st_r.cpf        <= CPF_RST;
         st_r.ni         <= NI_RST;
         st_r.bit_ratio  <= BIT_RATIO_RST;
         st_r.word_ratio <= WORD_RATIO_RST;
         st_r.setup      <= SETUP_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // bit clock from returned master clock, ratio 3 gives divide by 8
   ratio_divider u_bit_div (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .tick_in   (in_rise),
      .ratio     (st_r.bit_ratio),
      .phase_inv (st_r.setup[SETUP_BPH_BIT]),
      .clk_out   (bit_clk_raw),
      .fall_tick (bit_tick)
   );

   // word divider ticks once per bit clock period, on the falling half
   assign word_ratio_eff = word_div_ratio(st_r.word_ratio);

   ratio_divider u_word_div (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .tick_in   (bit_tick),
      .ratio     (word_ratio_eff),
      .phase_inv (st_r.setup[SETUP_WPH_BIT]),
      .clk_out   (word_clk_raw),
      .fall_tick ()
   );

   assign audio_master_clock_out     = st_r.acc[ACC_W-1];
   assign audio_bit_clock            = bit_clk_raw;
   assign audio_word_clock           = word_clk_raw;
   assign master_clock_voltage_range = st_r.setup[SETUP_VR_BIT];
   assign reg_rdata                  = st_r.rdata;
   assign field_count_last           = st_r.last;

endmodule // field_locked_audio_clock_gen

`default_nettype wire

// ==== design/audio_clock_pkg.sv ====
package audio_clock_pkg;

   // register subaddresses
   localparam logic [7:0] ADDR_CPF_LOW      = 8'h30;
   localparam logic [7:0] ADDR_CPF_MID      = 8'h31;
   localparam logic [7:0] ADDR_CPF_HIGH     = 8'h32;
   localparam logic [7:0] ADDR_RSVD_33      = 8'h33;
   localparam logic [7:0] ADDR_NI_LOW       = 8'h34;
   localparam logic [7:0] ADDR_NI_MID       = 8'h35;
   localparam logic [7:0] ADDR_NI_HIGH      = 8'h36;
   localparam logic [7:0] ADDR_RSVD_37      = 8'h37;
   localparam logic [7:0] ADDR_BIT_DIV      = 8'h38;
   localparam logic [7:0] ADDR_WORD_DIV     = 8'h39;
   localparam logic [7:0] ADDR_BASIC_SETUP  = 8'h3A;
   localparam logic [7:0] ADDR_RSVD_TAIL_LO = 8'h3B;
   localparam logic [7:0] ADDR_RSVD_TAIL_HI = 8'h3F;

   // field widths
   localparam int CPF_W   = 18;
   localparam int NI_W    = 22;
   localparam int ACC_W   = 23;
   localparam int RATIO_W = 6;

   // values after reset
   localparam logic [CPF_W-1:0]   CPF_RST        = 18'h0_0000;
   localparam logic [NI_W-1:0]    NI_RST         = 22'h00_0000;
   localparam logic [RATIO_W-1:0] BIT_RATIO_RST  = 6'h00;
   localparam logic [RATIO_W-1:0] WORD_RATIO_RST = 6'h00;
   localparam logic [3:0]         SETUP_RST      = 4'h0;

   // basic setup bit positions
   localparam int SETUP_LOOP_BIT  = 3;
   localparam int SETUP_VR_BIT    = 2;
   localparam int SETUP_WPH_BIT   = 1;
   localparam int SETUP_BPH_BIT   = 0;

   // timing
   localparam int MASTER_PER_SAMPLE = 256;
   localparam int BIT_PER_SAMPLE    = 32;
   localparam int TRIM_SHIFT        = 4;
   localparam int TRIM_LIMIT        = 4096;

endpackage : audio_clock_pkg

// ==== design/ratio_divider.sv ====
`timescale 1ns/1ps
`default_nettype none

// divides a qualified input tick stream by 2*(ratio+1)
// clk_sys must be well above twice the tick rate
module ratio_divider
   import audio_clock_pkg::*;
(
   // clock and reset
   input  wire logic               clk_sys,
   input  wire logic               rst,
   // source ticks
   input  wire logic               tick_in,
   input  wire logic [RATIO_W-1:0] ratio,
   input  wire logic               phase_inv,
   // divided output
   output logic                    clk_out,
   output logic                    fall_tick
);

   typedef struct packed {
      logic [RATIO_W-1:0] cnt;
      logic               lvl;
   } div_state_t;

   div_state_t st_r;
   div_state_t st_nxt;

   always_comb
   begin
      st_nxt    = st_r;
      fall_tick = 1'b0;
      if (tick_in)
      begin
         if (st_r.cnt >= ratio)
         begin
            st_nxt.cnt = '0;
            st_nxt.lvl = ~st_r.lvl;
            fall_tick  = st_r.lvl;
         end
         else
         begin
            st_nxt.cnt = st_r.cnt + 6'h01;
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign clk_out = st_r.lvl ^ phase_inv;

endmodule // ratio_divider

`default_nettype wire

// ==== tb/clock_gen_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module clock_gen_checker
   import audio_clock_pkg::*;
(
   // clock and reset
   input wire logic             clk_sys,
   input wire logic             rst,
   // register port
   input wire logic [7:0]       reg_addr,
   input wire logic [7:0]       reg_wdata,
   input wire logic             reg_wr,
   input wire logic             reg_rd,
   input wire logic [7:0]       reg_rdata,
   // video timing and clocks
   input wire logic             field_start,
   input wire logic             audio_master_clock_out,
   input wire logic             audio_master_clock_in,
   input wire logic             audio_bit_clock,
   input wire logic             audio_word_clock,
   input wire logic             master_clock_voltage_range,
   input wire logic [CPF_W-1:0] field_count_last
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved without a read");
   property p_clear; $fell(rst) |-> reg_rdata == 8'h00 && field_count_last == 18'h0_0000; endproperty
   a_clear: assert property (p_clear) else $error("outputs not cleared by reset");
   property p_rsvd; reg_rd && reg_addr == 8'h37 |=> reg_rdata == 8'h00; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved place reads nonzero");
   property p_cpf_hi; reg_rd && reg_addr == 8'h32 |=> reg_rdata[7:2] == 6'h00; endproperty
   a_cpf_hi: assert property (p_cpf_hi) else $error("field count top byte too wide");
   property p_ni_hi; reg_rd && reg_addr == 8'h36 |=> reg_rdata[7:6] == 2'h0; endproperty
   a_ni_hi: assert property (p_ni_hi) else $error("increment top byte too wide");
   property p_wdiv; reg_rd && reg_addr == 8'h39 |=> reg_rdata[7:6] == 2'h0; endproperty
   a_wdiv: assert property (p_wdiv) else $error("word ratio too wide");
   property p_setup; reg_rd && reg_addr == 8'h3A |=> reg_rdata[7:4] == 4'h0; endproperty
   a_setup: assert property (p_setup) else $error("setup upper nibble nonzero");
   property p_vr; reg_wr && reg_addr == 8'h3A |=> master_clock_voltage_range == $past(reg_wdata[2]); endproperty
   a_vr: assert property (p_vr) else $error("voltage range bit not followed");
   property p_bdiv;
      reg_wr && reg_addr == 8'h38 ##1 reg_rd && reg_addr == 8'h38 && !reg_wr
         |=> reg_rdata == {2'h0, $past(reg_wdata[5:0], 2)};
   endproperty
   a_bdiv: assert property (p_bdiv) else $error("bit ratio readback wrong");
endmodule // clock_gen_checker
bind field_locked_audio_clock_gen clock_gen_checker chk_i (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .field_start(field_start),
   .audio_master_clock_out(audio_master_clock_out), .audio_master_clock_in(audio_master_clock_in),
   .audio_bit_clock(audio_bit_clock), .audio_word_clock(audio_word_clock),
   .master_clock_voltage_range(master_clock_voltage_range), .field_count_last(field_count_last));
`default_nettype wire

// ==== tb/codec_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module codec_model
(
   // clocks from and to the generator
   input  wire logic master_out,
   output logic      master_in,
   input  wire logic bit_clk,
   input  wire logic word_clk,
   // observed frame length
   output logic [7:0] bits_per_word
);
   logic       word_q = 1'b0;
   logic [7:0] cnt    = 8'h00;
   assign master_in = master_out;
   // sample a little after the bit edge, both clocks leave the same register stage
   always @(posedge bit_clk)
   begin
      #1;
      if (word_clk && !word_q)
      begin
         bits_per_word = cnt;
         cnt = 8'h01;
      end
      else
         cnt = cnt + 8'h01;
      word_q = word_clk;
   end
endmodule // codec_model
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import audio_clock_pkg::*;
;
   logic             clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, field_start = 1'b0;
   logic [7:0]       reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, bpw;
   logic             mco, mci, bclk, wclk, vr;
   logic [CPF_W-1:0] fcl;
   int               bad_count = 0, cmp_count = 0;
   logic [7:0]       msk [17] = '{8'hFF, 8'hFF, 8'h03, 8'h00, 8'hFF, 8'hFF, 8'h3F, 8'h00, 8'h3F, 8'h3F, 8'h0F,
                                  8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   field_locked_audio_clock_gen dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .field_start(field_start),
      .audio_master_clock_out(mco), .audio_master_clock_in(mci), .audio_bit_clock(bclk),
      .audio_word_clock(wclk), .master_clock_voltage_range(vr), .field_count_last(fcl));
   codec_model partner (.master_out(mco), .master_in(mci), .bit_clk(bclk), .word_clk(wclk), .bits_per_word(bpw));
   initial forever #10 clk_sys = ~clk_sys;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(negedge clk_sys) reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_sys) {reg_addr, reg_rd} = {a, 1'b1};
      @(negedge clk_sys) reg_rd = 1'b0;
      chk(reg_rdata, exp);
   endtask
   function automatic logic sig(input int s);
      return (s == 0) ? mco : (s == 1) ? bclk : wclk;
   endfunction
   // bounded wait so a dead clock cannot hang the run
   task automatic rise(input int s, inout int n);
      while (sig(s) === 1'b1 && n < 9000) @(negedge clk_sys) n++;
      while (sig(s) !== 1'b1 && n < 9000) @(negedge clk_sys) n++;
   endtask
   task automatic per(input int s, input int exp);
      int n;
      n = 0;
      rise(s, n);
      n = 0;
      rise(s, n);
      chk(n, exp);
   endtask
   task automatic t_regs();
      rd(ADDR_BIT_DIV, 8'h00);
      for (int i = 0; i < 17; i++) wr(8'h30 + 8'(i), msk[i]);
      for (int i = 0; i < 17; i++) rd(8'h30 + 8'(i), msk[i]);
      chk(vr, 1'b1);
      // write then read at once, the read must see the new ratio
      @(negedge clk_sys) {reg_addr, reg_wdata, reg_wr} = {ADDR_BIT_DIV, 8'h2A, 1'b1};
      @(negedge clk_sys) {reg_wr, reg_rd} = 2'b01;
      @(negedge clk_sys) reg_rd = 1'b0;
      chk(reg_rdata, 8'h2A);
      $display("t_regs done");
   endtask
   task automatic t_clocks();
      wr(ADDR_NI_LOW, 8'h00);
      wr(ADDR_NI_MID, 8'h00);
      wr(ADDR_NI_HIGH, 8'h10);
      wr(ADDR_BIT_DIV, 8'h03);
      wr(ADDR_WORD_DIV, 8'h10);
      wr(ADDR_BASIC_SETUP, 8'h00);
      chk(vr, 1'b0);
      repeat (6200) @(negedge clk_sys);
      chk(bpw, 8'd32);
      per(0, 8);
      per(1, 64);
      per(2, 2048);
      wr(ADDR_BIT_DIV, 8'h3F);
      per(1, 1024);
      per(1, 1024);
      $display("t_clocks done");
   endtask
   task automatic t_field();
      wr(ADDR_BIT_DIV, 8'h03);
      // 800 cycle fields at 8 cycles per master period
      wr(ADDR_CPF_LOW, 8'h64);
      wr(ADDR_CPF_MID, 8'h00);
      wr(ADDR_CPF_HIGH, 8'h00);
      // open loop first, then with the loop on and a matching count
      for (int k = 0; k < 2; k++)
      begin
         wr(ADDR_BASIC_SETUP, (k == 0) ? 8'h00 : 8'h08);
         repeat (3)
         begin
            @(negedge clk_sys) field_start = 1'b1;
            @(negedge clk_sys) field_start = 1'b0;
            repeat (798) @(negedge clk_sys);
         end
         chk(fcl, 18'h0_0064);
      end
      $display("t_field done");
   endtask
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (40000) @(posedge clk_sys);
      bad_count++;
      wrap_up();
   end
   initial
   begin
      repeat (3) @(negedge clk_sys);
      rst = 1'b0;
      t_regs();
      t_clocks();
      t_field();
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
